// ==== include/brs_pkg.sv ====
// Purpose: constants and types for the boot and hold-button reset sequencer
// Assumes: 10 MHz system clock, one-second tick derived by a divider
// Notes: APB register map and display codes live here
// What this block does
// RULE1: fault lamp on at power-up
// RULE2: missing card, image or key halts, lamp on
// RULE3: failed authenticity check halts, lamp on
// RULE4: boot start: lamp off, point animation
// RULE5: animation over 30 seconds is boot error
// RULE6: show version two seconds, then address/errors
// RULE7: unassigned address shows auto prefix
// RULE8: then set configured startup application state
// RULE9: button ignored unless switch three closed
// RULE10: log every button operation
// RULE11: hold over 5 s selects clear exception
// RULE12: after 1 s count 4-1, release aborts
// RULE13: countdown done shows pending reset code
// RULE14: halt running application before clear reset
// RULE15: second countdown, release means clear exception
// RULE16: past 10 s pending config code, release resets
// RULE17: config reset halts application, stores data
// RULE18: after config reset application stays stopped
// RULE19: third countdown, release means config reset
// RULE20: pending factory code held until release
// RULE21: factory reset restores defaults, deletes files
// RULE22: factory reset halts application, stores data
// RULE23: button synchronised, debounced, one-second tick timed
// RULE24: states stopped, run, logic-halted, error
package brs_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned TICK_CYC = CLK_HZ;
   localparam int unsigned BOOT_LIMIT_S = 30;
   localparam int unsigned VERSION_S = 2;
   localparam int unsigned DEBOUNCE_MS = 10;
   localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_EVENT = 8'h08;
   localparam logic [7:0] ADDR_VERSION = 8'h0C;
   // control bit positions
   localparam int CTRL_CARD = 0;
   localparam int CTRL_IMAGE = 1;
   localparam int CTRL_KEY = 2;
   localparam int CTRL_CHK_DONE = 3;
   localparam int CTRL_CHK_OK = 4;
   localparam int CTRL_OS_UP = 5;
   localparam int CTRL_ADDR_SET = 6;
   localparam int CTRL_START_LSB = 8;
   localparam int CTRL_HALT_ACK = 10;
   localparam int CTRL_EVT_ACK = 11;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   typedef enum logic [1:0] {APP_STOP, APP_RUN, APP_LHALT, APP_ERROR} brs_app_e;
   typedef enum logic [2:0] {ACT_NONE, ACT_CLEAR, ACT_CONFIG, ACT_FACTORY} brs_act_e;
   typedef enum logic [3:0] {
      DSP_BLANK, DSP_ANIM, DSP_VERSION, DSP_ADDR, DSP_AUTO_ADDR, DSP_COUNT,
      DSP_PENDING_RESET, DSP_PENDING_CONFIG, DSP_PENDING_FACTORY, DSP_BOOT_ERR
   } brs_dsp_e;
endpackage : brs_pkg

// ==== src/brs_seq.sv ====
// Purpose: startup sequencing and hold-time pushbutton interpretation
// Assumes: pins synchronous except the button and arst_n, both synchronised here
// Notes: firmware reports boot checks through the control register
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module brs_seq #(
   parameter int unsigned TICK_CYC = brs_pkg::TICK_CYC,
   parameter int unsigned DEBOUNCE_CYC = brs_pkg::DEBOUNCE_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic button_n,
   input wire logic mode_sw3,
   output logic fault_lamp,
   output logic [3:0] display_code,
   output logic [2:0] display_count,
   output logic [1:0] app_state,
   output logic app_halt_req,
   output logic store_data_req,
   output logic cfg_default_req,
   output logic user_wipe_req,
   output logic ctrl_reset_req,
   output logic event_log_pulse,
   output logic [1:0] event_log_kind
);
   typedef enum logic [2:0] {
      ST_CHECK, ST_HALTED, ST_BOOT, ST_VERSION, ST_SHOW, ST_BOOT_ERR
   } brs_boot_e;
   typedef enum logic [2:0] {
      BT_IDLE, BT_WAIT, BT_COUNT, BT_PEND, BT_HALT, BT_FIRE
   } brs_btn_e;

   typedef struct packed {
      logic [1:0] btn_sync;
      logic btn_db;
      logic [23:0] db_cnt;
      logic [23:0] div_cnt;
      logic tick;
      brs_boot_e boot;
      logic [5:0] sec_cnt;
      brs_btn_e btn;
      logic [4:0] hold_s;
      logic [2:0] level;
      logic [2:0] count;
      logic keep_stopped;
      logic [31:0] ctrl;
      logic [7:0] evt_cnt;
      logic [1:0] app;
      logic fault;
      logic [3:0] dsp;
      logic halt_req;
      logic store_req;
      logic cfg_req;
      logic wipe_req;
      logic rst_req;
      logic evt_pulse;
      logic [1:0] evt_kind;
      logic [31:0] rdata;
      logic ready;
   } brs_state_s;

   brs_state_s s_q;
   brs_state_s s_d;
   // reset synchroniser sits outside the state word: it cannot be reset by its own output
   logic [1:0] rst_sync_q;
   logic rst_n;

   assign rst_n = rst_sync_q[1];

   function automatic logic app_active(input logic [1:0] a);
      return a == 2'(brs_pkg::APP_RUN) || a == 2'(brs_pkg::APP_LHALT);
   endfunction : app_active

   // level 1 = clear exception, 2 = config reset, 3 = factory reset
   function automatic logic [3:0] pend_code(input logic [2:0] lvl);
      case (lvl)
         3'd1: return 4'(brs_pkg::DSP_PENDING_RESET);
         3'd2: return 4'(brs_pkg::DSP_PENDING_CONFIG);
         default: return 4'(brs_pkg::DSP_PENDING_FACTORY);
      endcase
   endfunction : pend_code

   // address view; the prefix form stands when nothing assigned an address
   function automatic logic [3:0] addr_code(input logic [31:0] c);
      return c[brs_pkg::CTRL_ADDR_SET] ? 4'(brs_pkg::DSP_ADDR) : 4'(brs_pkg::DSP_AUTO_ADDR);
   endfunction : addr_code

   always_comb begin
      s_d = s_q;
      s_d.evt_pulse = 1'b0;
      s_d.ready = 1'b0;
      // [RULE23] synchronise and debounce the active-low button
      s_d.btn_sync = {s_q.btn_sync[0], ~button_n};
      if (s_q.btn_sync[1] == s_q.btn_db) begin
         s_d.db_cnt = '0;
      end else if (s_q.db_cnt == 24'(DEBOUNCE_CYC - 1)) begin
         s_d.btn_db = s_q.btn_sync[1];
         s_d.db_cnt = '0;
      end else begin
         s_d.db_cnt = s_q.db_cnt + 24'd1;
      end
      // [RULE23] one-second tick
      s_d.tick = 1'b0;
      if (s_q.div_cnt == 24'(TICK_CYC - 1)) begin
         s_d.div_cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 24'd1;
      end

      case (s_q.boot)
         brs_boot_e'(ST_CHECK): begin
            s_d.fault = 1'b1; // [RULE1]
            if (!(s_q.ctrl[brs_pkg::CTRL_CARD] && s_q.ctrl[brs_pkg::CTRL_IMAGE]
                  && s_q.ctrl[brs_pkg::CTRL_KEY])) begin
               s_d.boot = s_q.boot; // [RULE2] wait; firmware sees lamp on
            end else if (s_q.ctrl[brs_pkg::CTRL_CHK_DONE]) begin
               if (s_q.ctrl[brs_pkg::CTRL_CHK_OK]) begin
                  s_d.boot = ST_BOOT;
                  s_d.fault = 1'b0; // [RULE4]
                  s_d.dsp = 4'(brs_pkg::DSP_ANIM); // [RULE4]
                  s_d.sec_cnt = '0;
                  // restart the second divider so the boot limit counts from here
                  s_d.div_cnt = '0;
                  s_d.tick = 1'b0;
               end else begin
                  s_d.boot = ST_HALTED; // [RULE3]
               end
            end
         end
         brs_boot_e'(ST_HALTED): begin
            s_d.fault = 1'b1; // [RULE3] only a failed check reaches here
         end
         brs_boot_e'(ST_BOOT): begin
            if (s_q.ctrl[brs_pkg::CTRL_OS_UP]) begin
               s_d.boot = ST_VERSION;
               s_d.dsp = 4'(brs_pkg::DSP_VERSION); // [RULE6]
               s_d.sec_cnt = '0;
               s_d.div_cnt = '0;
               s_d.tick = 1'b0;
            end else if (s_q.tick) begin
               if (s_q.sec_cnt == 6'(brs_pkg::BOOT_LIMIT_S)) begin
                  s_d.boot = ST_BOOT_ERR; // [RULE5]
                  s_d.dsp = 4'(brs_pkg::DSP_BOOT_ERR);
                  s_d.app = 2'(brs_pkg::APP_ERROR);
               end else begin
                  s_d.sec_cnt = s_q.sec_cnt + 6'd1;
               end
            end
         end
         brs_boot_e'(ST_VERSION): begin
            if (s_q.tick) begin
               s_d.sec_cnt = s_q.sec_cnt + 6'd1;
               if (s_q.sec_cnt == 6'(brs_pkg::VERSION_S - 1)) begin
                  s_d.boot = ST_SHOW;
                  s_d.dsp = addr_code(s_q.ctrl); // [RULE6] [RULE7]
                  // [RULE8] [RULE18]
                  s_d.app = s_q.keep_stopped ? 2'(brs_pkg::APP_STOP) :
                     s_q.ctrl[brs_pkg::CTRL_START_LSB +: 2];
                  s_d.keep_stopped = 1'b0;
               end
            end
         end
         default: begin
         end
      endcase

      // pushbutton, only in the address view or after a boot error [RULE24]
      case (s_q.btn)
         brs_btn_e'(BT_IDLE): begin
            if (s_q.btn_db && mode_sw3 && s_q.boot inside {ST_SHOW, ST_BOOT_ERR}) begin // [RULE9]
               s_d.btn = BT_WAIT;
               s_d.hold_s = '0;
               s_d.level = 3'd0;
               s_d.div_cnt = '0;
               s_d.tick = 1'b0; // a tick already under way would cut the first second
            end
         end
         brs_btn_e'(BT_WAIT), brs_btn_e'(BT_COUNT): begin
            if (!s_q.btn_db) begin
               // [RULE12] abort, [RULE15] [RULE19] fall back one level
               if (s_q.level == 3'd0) begin
                  s_d.btn = BT_IDLE;
                  // back to whatever stood before the press
                  s_d.dsp = s_q.boot == ST_BOOT_ERR ? 4'(brs_pkg::DSP_BOOT_ERR) :
                     addr_code(s_q.ctrl); // [RULE7]
               end else begin
                  s_d.btn = BT_HALT;
               end
            end else if (s_q.tick) begin
               if (s_q.btn == BT_WAIT) begin
                  s_d.btn = BT_COUNT; // [RULE12] [RULE15] [RULE19]
                  s_d.count = 3'd4;
                  s_d.dsp = 4'(brs_pkg::DSP_COUNT);
               end else if (s_q.count == 3'd1) begin
                  s_d.btn = BT_PEND;
                  s_d.level = s_q.level + 3'd1;
                  s_d.dsp = pend_code(s_q.level + 3'd1); // [RULE13] [RULE16] [RULE20]
               end else begin
                  s_d.count = s_q.count - 3'd1;
               end
            end
         end
         brs_btn_e'(BT_PEND): begin
            if (!s_q.btn_db) begin
               s_d.btn = BT_HALT; // [RULE13] [RULE16] [RULE20]
            end else if (s_q.tick && s_q.level != 3'd3) begin
               s_d.btn = BT_COUNT; // [RULE15] [RULE19]
               s_d.count = 3'd4;
               s_d.dsp = 4'(brs_pkg::DSP_COUNT);
            end
         end
         brs_btn_e'(BT_HALT): begin
            // [RULE14] [RULE17] [RULE22]
            if (app_active(s_q.app) && !s_q.ctrl[brs_pkg::CTRL_HALT_ACK]) begin
               s_d.halt_req = 1'b1;
               s_d.store_req = s_q.level != 3'd1;
            end else begin
               s_d.halt_req = 1'b0;
               s_d.store_req = 1'b0;
               s_d.app = 2'(brs_pkg::APP_STOP);
               s_d.btn = BT_FIRE;
               s_d.evt_pulse = 1'b1; // [RULE10]
               s_d.evt_kind = s_q.level[1:0];
               s_d.evt_cnt = s_q.evt_cnt + 8'd1;
               s_d.cfg_req = s_q.level != 3'd1; // [RULE16] [RULE21]
               s_d.wipe_req = s_q.level == 3'd3; // [RULE21]
               s_d.keep_stopped = s_q.level != 3'd1; // [RULE18]
               s_d.rst_req = 1'b1; // [RULE11]
            end
         end
         brs_btn_e'(BT_FIRE): begin
            // requests stand until firmware sets the event acknowledge bit, then the boot check restarts
            if (s_q.ctrl[brs_pkg::CTRL_EVT_ACK]) begin
               s_d.cfg_req = 1'b0;
               s_d.wipe_req = 1'b0;
               s_d.rst_req = 1'b0;
               s_d.btn = BT_IDLE;
               s_d.boot = ST_CHECK;
               s_d.dsp = 4'(brs_pkg::DSP_BLANK);
            end
         end
         default: s_d.btn = BT_IDLE;
      endcase

      // apb slave, one wait state
      if (psel && penable && !s_q.ready) begin
         s_d.ready = 1'b1;
         case (paddr)
            brs_pkg::ADDR_CTRL: begin
               if (pwrite) begin
                  s_d.ctrl = pwdata;
               end
               s_d.rdata = s_q.ctrl;
            end
            brs_pkg::ADDR_STATUS: begin
               s_d.rdata = {16'h0000, 1'(s_q.keep_stopped), s_q.level, 1'(s_q.fault),
                            s_q.btn, s_q.boot, s_q.app, s_q.count};
            end
            brs_pkg::ADDR_EVENT: s_d.rdata = {24'h0000_00, s_q.evt_cnt};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.boot <= ST_CHECK;
         s_q.fault <= 1'b1;
         s_q.btn <= BT_IDLE;
         s_q.ctrl <= brs_pkg::CTRL_RST;
         s_q.app <= 2'(brs_pkg::APP_STOP);
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = 1'b0;
   assign fault_lamp = s_q.fault;
   assign display_code = s_q.dsp;
   assign display_count = s_q.count;
   assign app_state = s_q.app;
   assign app_halt_req = s_q.halt_req;
   assign store_data_req = s_q.store_req;
   assign cfg_default_req = s_q.cfg_req;
   assign user_wipe_req = s_q.wipe_req;
   assign ctrl_reset_req = s_q.rst_req;
   assign event_log_pulse = s_q.evt_pulse;
   assign event_log_kind = s_q.evt_kind;

   property p_lamp_halt;
      @(posedge clk_sys) disable iff (!rst_n) s_q.boot == ST_HALTED |-> fault_lamp;
   endproperty
   a_lamp_halt: assert property (p_lamp_halt) else $error("lamp off while halted"); // [RULE3]

   property p_boot_lamp;
      @(posedge clk_sys) disable iff (!rst_n)
         s_q.boot == ST_BOOT |-> !fault_lamp && display_code == 4'(brs_pkg::DSP_ANIM);
   endproperty
   a_boot_lamp: assert property (p_boot_lamp) else $error("boot display wrong"); // [RULE4]

   property p_sw3;
      @(posedge clk_sys) disable iff (!rst_n)
         s_q.btn == BT_IDLE && !mode_sw3 |=> s_q.btn == BT_IDLE;
   endproperty
   a_sw3: assert property (p_sw3) else $error("button taken without switch"); // [RULE9]

   property p_log;
      @(posedge clk_sys) disable iff (!rst_n) $rose(ctrl_reset_req) |-> event_log_pulse;
   endproperty
   a_log: assert property (p_log) else $error("reset without log entry"); // [RULE10]

   property p_halt_first;
      @(posedge clk_sys) disable iff (!rst_n)
         $rose(ctrl_reset_req) |-> app_state == 2'(brs_pkg::APP_STOP);
   endproperty
   a_halt_first: assert property (p_halt_first) else $error("reset while running"); // [RULE14]

   property p_wipe;
      @(posedge clk_sys) disable iff (!rst_n) user_wipe_req |-> cfg_default_req;
   endproperty
   a_wipe: assert property (p_wipe) else $error("wipe without defaults"); // [RULE21]

   property p_count;
      @(posedge clk_sys) disable iff (!rst_n)
         s_q.btn == BT_COUNT |-> display_count >= 3'd1 && display_count <= 3'd4;
   endproperty
   a_count: assert property (p_count) else $error("countdown out of range"); // [RULE12]

   property p_factory_hold;
      @(posedge clk_sys) disable iff (!rst_n)
         s_q.btn == BT_PEND && s_q.level == 3'd3 && s_q.btn_db |=> s_q.btn == BT_PEND;
   endproperty
   a_factory_hold: assert property (p_factory_hold) else $error("factory code left"); // [RULE20]

   sequence s_pend_release;
      s_q.btn == BT_PEND && !s_q.btn_db;
   endsequence

   property p_rel_fire;
      @(posedge clk_sys) disable iff (!rst_n) s_pend_release |=> s_q.btn == BT_HALT;
   endproperty
   a_rel_fire: assert property (p_rel_fire) else $error("release ignored"); // [RULE13]

   property p_abort;
      @(posedge clk_sys) disable iff (!rst_n)
         s_q.btn == BT_COUNT && s_q.level == 3'd0 && !s_q.btn_db |=> s_q.btn == BT_IDLE;
   endproperty
   a_abort: assert property (p_abort) else $error("aborted press still active"); // [RULE12]

   sequence s_ver_hold;
      display_code == 4'(brs_pkg::DSP_VERSION) [*8];
   endsequence

   property p_ver_hold;
      @(posedge clk_sys) disable iff (!rst_n) $rose(s_q.boot == ST_VERSION) |-> s_ver_hold;
   endproperty
   a_ver_hold: assert property (p_ver_hold) else $error("version shown too briefly"); // [RULE6]
endmodule : brs_seq

// ==== verification/brs_panel.sv ====
// Purpose: front-panel model: recessed reset button with contact bounce and mode switch three
// Assumes: button contact is active low with a pull-up, so a released button reads high
// Notes: each button transition carries a one-cycle glitch, shorter than the debounce window; switch three changes cleanly
`timescale 1ns/1ps
module brs_panel (
   input wire logic clk_sys,
   output logic button_n,
   output logic mode_sw3
);
   initial begin
      button_n = 1'b1;
      mode_sw3 = 1'b0;
   end

   task automatic set_sw3(input logic closed);
      @(posedge clk_sys);
      mode_sw3 <= closed;
   endtask : set_sw3

   // a real contact chatters, so the level flips back once before it settles
   task automatic push(input logic down);
      @(posedge clk_sys);
      button_n <= ~down;
      @(posedge clk_sys);
      button_n <= down;
      @(posedge clk_sys);
      button_n <= ~down;
   endtask : push
endmodule : brs_panel

// ==== verification/brs_seq_tb.sv ====
// Purpose: self-checking bench for startup gating and hold-time button actions
// Assumes: tick shortened to 20 cycles and debounce to 2 cycles
// Notes: every hold case restarts the block with the application running
`timescale 1ns/1ps
module brs_seq_tb;
   localparam int unsigned TICK = 20;
   localparam int LIMIT = 30000;
   localparam logic [31:0] RUN_CTRL = 32'h0000_013F;
   logic clk_sys, arst_n, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata, rd;
   logic pready, pslverr, button_n, mode_sw3, fault_lamp, app_halt_req, store_data_req;
   logic cfg_default_req, user_wipe_req, ctrl_reset_req, event_log_pulse;
   logic [3:0] display_code;
   logic [2:0] display_count;
   logic [1:0] app_state, event_log_kind, ev_kind;
   int bad_count = 0;
   int checks_done = 0;
   int ev_cnt = 0;
   int cyc = 0;

   always #50 clk_sys = ~clk_sys;

   brs_seq #(.TICK_CYC(TICK), .DEBOUNCE_CYC(2)) dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .button_n(button_n), .mode_sw3(mode_sw3), .fault_lamp(fault_lamp),
      .display_code(display_code), .display_count(display_count), .app_state(app_state),
      .app_halt_req(app_halt_req), .store_data_req(store_data_req),
      .cfg_default_req(cfg_default_req), .user_wipe_req(user_wipe_req),
      .ctrl_reset_req(ctrl_reset_req), .event_log_pulse(event_log_pulse),
      .event_log_kind(event_log_kind)
   );

   brs_panel panel (.clk_sys(clk_sys), .button_n(button_n), .mode_sw3(mode_sw3));

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (event_log_pulse === 1'b1) begin
         ev_cnt <= ev_cnt + 1;
         ev_kind <= event_log_kind;
      end
      if (cyc == LIMIT) begin
         bad_count++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      chk(pslverr, 1'b0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_disp(input logic [3:0] code, input int ticks);
      int n;
      n = 0;
      while (display_code !== code && n < ticks * TICK) begin
         @(posedge clk_sys);
         n++;
      end
      chk(display_code, code);
   endtask : wait_disp

   task automatic boot(input logic [31:0] ctrl);
      @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(fault_lamp, 1'b1);
      chk(app_state, brs_pkg::APP_STOP);
      apb(1'b1, brs_pkg::ADDR_CTRL, ctrl);
   endtask : boot

   task automatic hold_case(input logic [3:0] c1, input logic [3:0] c2, input logic [1:0] kind);
      int n;
      int e0;
      n = 0;
      boot(RUN_CTRL);
      wait_disp(brs_pkg::DSP_AUTO_ADDR, 4);
      e0 = ev_cnt;
      panel.push(1'b1);
      wait_disp(c1, 17);
      wait_disp(c2, 2);
      if (c2 == brs_pkg::DSP_COUNT) chk(display_count, 3'd4);
      if (kind == 2'd3) begin
         repeat (3 * TICK) @(posedge clk_sys);
         chk(display_code, c2);
      end
      panel.push(1'b0);
      while (app_halt_req !== 1'b1 && n < 4 * TICK) begin
         @(posedge clk_sys);
         n++;
      end
      chk(app_halt_req, 1'b1);
      chk(ctrl_reset_req, 1'b0);
      chk(store_data_req, kind > 2'd1);
      apb(1'b1, brs_pkg::ADDR_CTRL, RUN_CTRL | 32'h0000_0400);
      n = 0;
      while (ctrl_reset_req !== 1'b1 && n < 4 * TICK) begin
         @(posedge clk_sys);
         n++;
      end
      chk(ctrl_reset_req, 1'b1);
      @(posedge clk_sys);
      chk(ev_cnt, e0 + 1);
      chk(ev_kind, kind);
      chk(cfg_default_req, kind > 2'd1);
      chk(user_wipe_req, kind == 2'd3);
      apb(1'b1, brs_pkg::ADDR_CTRL, RUN_CTRL | 32'h0000_0C00);
      wait_disp(brs_pkg::DSP_AUTO_ADDR, 4);
      chk(app_state, kind > 2'd1 ? brs_pkg::APP_STOP : brs_pkg::APP_RUN);
   endtask : hold_case

   initial begin
      clk_sys = 1'b0;
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      boot(32'h0000_001B);
      repeat (5) @(posedge clk_sys);
      chk(fault_lamp, 1'b1);
      apb(1'b1, brs_pkg::ADDR_CTRL, 32'h0000_000F);
      repeat (5) @(posedge clk_sys);
      chk(fault_lamp, 1'b1);
      apb(1'b1, brs_pkg::ADDR_CTRL, 32'h0000_001F);
      repeat (5) @(posedge clk_sys);
      chk(fault_lamp, 1'b1);
      boot(32'h0000_001F);
      wait_disp(brs_pkg::DSP_ANIM, 1);
      chk(fault_lamp, 1'b0);
      apb(1'b0, brs_pkg::ADDR_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_001F);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // animation must still run just inside the limit, then flip to the error code
      repeat (29 * TICK) @(posedge clk_sys);
      chk(display_code, brs_pkg::DSP_ANIM);
      wait_disp(brs_pkg::DSP_BOOT_ERR, 4);
      boot(RUN_CTRL);
      wait_disp(brs_pkg::DSP_VERSION, 4);
      repeat (TICK / 2) @(posedge clk_sys);
      chk(display_code, brs_pkg::DSP_VERSION);
      wait_disp(brs_pkg::DSP_AUTO_ADDR, 2);
      chk(app_state, brs_pkg::APP_RUN);
      panel.push(1'b1);
      repeat (7 * TICK) @(posedge clk_sys);
      chk(display_code, brs_pkg::DSP_AUTO_ADDR);
      chk(ev_cnt, 0);
      panel.push(1'b0);
      panel.set_sw3(1'b1);
      panel.push(1'b1);
      wait_disp(brs_pkg::DSP_COUNT, 3);
      chk(display_count, 3'd4);
      panel.push(1'b0);
      repeat (TICK) @(posedge clk_sys);
      chk(display_code, brs_pkg::DSP_AUTO_ADDR);
      chk(ev_cnt, 0);
      hold_case(brs_pkg::DSP_PENDING_RESET, brs_pkg::DSP_PENDING_RESET, 2'd1);
      hold_case(brs_pkg::DSP_PENDING_RESET, brs_pkg::DSP_COUNT, 2'd1);
      hold_case(brs_pkg::DSP_PENDING_CONFIG, brs_pkg::DSP_PENDING_CONFIG, 2'd2);
      hold_case(brs_pkg::DSP_PENDING_CONFIG, brs_pkg::DSP_COUNT, 2'd2);
      hold_case(brs_pkg::DSP_PENDING_FACTORY, brs_pkg::DSP_PENDING_FACTORY, 2'd3);
      final_report();
   end
endmodule : brs_seq_tb
